// ---- sarc_pkg.sv ----
// Constants and types of the standby and reset control block
package sarc_pkg;

  // Bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int IRQ_N = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CORE = 8'h10;
  localparam logic [7:0] OFS_TMODE = 8'h14;
  localparam logic [7:0] OFS_COUNTER = 8'h18;
  localparam logic [7:0] OFS_INTERVAL = 8'h1c;

  // Command register bits
  localparam int CMD_STOP = 0;
  localparam int CMD_HALT = 1;

  // Configuration register bits
  localparam int CFG_W = 5;
  localparam int CFG_CPU_SUB = 0;
  localparam int CFG_SER_EXT = 1;
  localparam int CFG_CNT_PIN = 2;
  localparam int CFG_WATCH_SUB = 3;
  localparam int CFG_DISP_SUB = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;

  // Interrupt source positions
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_EXT2 = 2;
  localparam int IRQ_EXT4 = 3;
  localparam int IRQ_INTERVAL = 4;
  localparam logic [IRQ_N-1:0] IRQ_EN_RST = 8'h00;

  // Program word layout for the reset vector
  localparam int PW_W = 8;
  localparam int PC_W = 14;
  localparam int PC_HI_W = 6;
  localparam int MBE_BIT = 7;

  // Core register fields
  localparam int CORE_PC = 0;
  localparam int CORE_MBE = 14;
  localparam int CORE_SK = 15;
  localparam int SK_W = 3;
  localparam int CORE_IST = 18;
  localparam int CORE_MBS = 19;
  localparam int MBS_W = 4;
  localparam int CORE_CY = 23;

  // Timer mode register fields
  localparam int TM_IVL = 0;
  localparam int IVL_MODE_W = 4;
  localparam int TM_WATCH = 8;
  localparam int WATCH_MODE_W = 8;

  // Event counter register fields
  localparam int CNT_W = 8;
  localparam int CN_MOD = 0;
  localparam int CN_MODE = 8;
  localparam int CN_OE = 16;
  localparam int CN_OUT = 17;
  localparam int CN_VAL = 24;
  localparam logic [CNT_W-1:0] MODULO_RST = 8'hff;

  // Interval register fields
  localparam int IV_FLAG = 8;

  // Data memory words lost even on a reset in standby
  localparam logic [11:0] RAM_HOLE_LO = 12'h0f8;
  localparam logic [11:0] RAM_HOLE_HI = 12'h0fd;

  // Standby sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STOP = 3'b010,
    ST_HALT = 3'b100
  } sarc_state_type;

endpackage

// ---- sarc_boot_if.sv ----
// Interface carrying the reset vector between loader and control core
`timescale 1ns/1ps
`default_nettype none

interface sarc_boot_if;
  logic [sarc_pkg::PW_W-1:0] word0;
  logic [sarc_pkg::PW_W-1:0] word1;
  logic standby;
  logic [sarc_pkg::PC_W-1:0] pc_vec;
  logic mbe_vec;
  logic retain;

  modport loader (
    input word0,
    input word1,
    input standby,
    output pc_vec,
    output mbe_vec,
    output retain
  );

  modport core (
    output word0,
    output word1,
    output standby,
    input pc_vec,
    input mbe_vec,
    input retain
  );
endinterface

`default_nettype wire

// ---- sarc_vector_load.sv ----
// Reset vector and bank enable decode from the first program words
`timescale 1ns/1ps
`default_nettype none

module sarc_vector_load (
  sarc_boot_if.loader boot
);
  import sarc_pkg::*;

  // High bits from word 0, low byte from word 1
  assign boot.pc_vec = {boot.word0[PC_HI_W-1:0], boot.word1};
  // Bank enable from the top bit of word 0
  assign boot.mbe_vec = boot.word0[MBE_BIT];
  // Context survives only a reset taken in standby
  assign boot.retain = boot.standby;
endmodule

`default_nettype wire

// ---- sarc_top.sv ----
// Standby sequencing, reset loading and register access
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sarc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sarc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sarc_pkg::DAT_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [sarc_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic [sarc_pkg::IRQ_N-1:0] irq_req_i,
  input wire logic main_osc_ok_i,
  input wire logic [sarc_pkg::PW_W-1:0] prog_word0_i,
  input wire logic [sarc_pkg::PW_W-1:0] prog_word1_i,
  input wire logic interval_tick_i,
  input wire logic counter_tick_i,
  input wire logic counter_external_input_pin_i,
  output logic main_osc_stop_o,
  output logic cpu_clk_en_o,
  output logic interval_run_o,
  output logic serial_run_o,
  output logic counter_run_o,
  output logic watch_run_o,
  output logic display_run_o,
  output logic wake_o,
  output logic [sarc_pkg::PC_W-1:0] pc_o,
  output logic bank_enable_flag_o,
  output logic [sarc_pkg::SK_W-1:0] skip_flags_o,
  output logic interrupt_status_flag_o,
  output logic [sarc_pkg::MBS_W-1:0] bank_select_reg_o,
  output logic carry_flag_o,
  output logic ram_retain_o,
  output logic ram_hole_clear_o,
  output logic counter_out_o
);
  import sarc_pkg::*;

  sarc_state_type state_q = ST_RUN;
  sarc_state_type state_d;
  logic keep_acc_q = 1'b0;
  logic [CFG_W-1:0] cfg_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic [IVL_MODE_W-1:0] interval_timer_mode_reg_q;
  logic [WATCH_MODE_W-1:0] watch_timer_mode_reg_q;
  logic [CNT_W-1:0] counter_modulo_reg_q;
  logic [CNT_W-1:0] counter_mode_reg_q;
  logic [CNT_W-1:0] event_count_value_q;
  logic counter_output_enable_q;
  logic pin_q;
  logic [CNT_W-1:0] interval_count_value_q;
  logic interval_timer_request_flag_q;
  logic [DAT_W-1:0] be_mask;
  logic [IRQ_N-1:0] ivl_vec;
  logic [IRQ_N-1:0] sb_mask;
  logic [DAT_W-1:0] rd_mux;

  sarc_boot_if boot ();

  // Reset vector decode
  sarc_vector_load u_load (
    .boot(boot.loader)
  );

  assign boot.word0 = prog_word0_i;
  assign boot.word1 = prog_word1_i;
  assign boot.standby = state_q != ST_RUN;

  // Byte lane masks from the select lines
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign be_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
    end
  endgenerate

  // Bus decode; a write commits at the edge where ack is high
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & wb_ack_o;
  wire [DAT_W-1:0] wdat = wb_dat_i & be_mask;
  wire hit_cmd = wb_adr_i == OFS_CMD;
  wire hit_cfg = wb_adr_i == OFS_CFG;
  wire hit_ien = wb_adr_i == OFS_IRQ_EN;
  wire hit_sts = wb_adr_i == OFS_STATUS;
  wire hit_core = wb_adr_i == OFS_CORE;
  wire hit_tm = wb_adr_i == OFS_TMODE;
  wire hit_cn = wb_adr_i == OFS_COUNTER;
  wire hit_iv = wb_adr_i == OFS_INTERVAL;
  wire wr_core = bus_wr & hit_core;
  wire wr_tm = bus_wr & hit_tm;
  wire wr_cn = bus_wr & hit_cn;
  wire clr_ivl = bus_wr & hit_iv & wdat[IV_FLAG];

  // Standby commands, one per standby state
  wire cmd_stop = bus_wr & hit_cmd & wdat[CMD_STOP];
  wire cmd_halt = bus_wr & hit_cmd & wdat[CMD_HALT];

  // Wake sources; line zero is dead while in standby
  wire standby = state_q != ST_RUN;
  assign ivl_vec = {{(IRQ_N-1){1'b0}}, interval_timer_request_flag_q}
                   << IRQ_INTERVAL;
  assign sb_mask = ~({{(IRQ_N-1){1'b0}}, 1'b1} << IRQ_EXT0);
  wire [IRQ_N-1:0] live_src = (irq_req_i | ivl_vec) & irq_en_q
                              & (standby ? sb_mask : {IRQ_N{1'b1}});
  wire wake = standby & (|live_src);

  // Standby sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (cmd_stop && !cfg_q[CFG_CPU_SUB]) begin
          state_d = ST_STOP;
        end else if (cmd_halt) begin
          state_d = ST_HALT;
        end
      end
      ST_STOP: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Peripheral run conditions per state
  wire in_stop = state_q == ST_STOP;
  wire main_ok = !in_stop && main_osc_ok_i;
  wire ivl_run_d = main_ok;
  wire ser_run_d = in_stop ? cfg_q[CFG_SER_EXT] : main_ok;
  wire cnt_run_d = in_stop ? cfg_q[CFG_CNT_PIN] : main_ok;
  wire wat_run_d = in_stop ? cfg_q[CFG_WATCH_SUB] : 1'b1;
  wire dsp_run_d = in_stop ? cfg_q[CFG_DISP_SUB] : 1'b1;

  // State register and wake pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      wake_o <= wake;
    end
  end

  // Clock and peripheral enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_stop_o <= 1'b0;
      cpu_clk_en_o <= 1'b1;
      {interval_run_o, serial_run_o, counter_run_o} <= 3'h0;
      {watch_run_o, display_run_o} <= 2'h0;
    end else if (ce_i) begin
      main_osc_stop_o <= in_stop;
      cpu_clk_en_o <= !standby;
      {interval_run_o, serial_run_o, counter_run_o} <=
        {ivl_run_d, ser_run_d, cnt_run_d};
      {watch_run_o, display_run_o} <= {wat_run_d, dsp_run_d};
    end
  end

  // Standby seen at any edge of the reset decides retention
  wire keep_w = keep_acc_q | boot.retain;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keep_acc_q <= keep_w;
      ram_retain_o <= keep_w;
      ram_hole_clear_o <= 1'b1;
    end else if (ce_i) begin
      keep_acc_q <= 1'b0;
      ram_hole_clear_o <= 1'b0;
    end
  end

  // Core flags: vector load, clears and software access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= boot.pc_vec;
      bank_enable_flag_o <= boot.mbe_vec;
      skip_flags_o <= '0;
      interrupt_status_flag_o <= 1'b0;
      bank_select_reg_o <= '0;
      carry_flag_o <= keep_w & carry_flag_o;
    end else if (ce_i && wr_core) begin
      skip_flags_o <= (skip_flags_o & ~be_mask[CORE_SK +: SK_W])
                      | wdat[CORE_SK +: SK_W];
      interrupt_status_flag_o <= be_mask[CORE_IST] ? wdat[CORE_IST]
                                 : interrupt_status_flag_o;
      bank_select_reg_o <= (bank_select_reg_o & ~be_mask[CORE_MBS +: MBS_W])
                           | wdat[CORE_MBS +: MBS_W];
      carry_flag_o <= be_mask[CORE_CY] ? wdat[CORE_CY] : carry_flag_o;
    end
  end

  // Configuration and interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (ce_i && bus_wr) begin
      if (hit_cfg) begin
        cfg_q <= (cfg_q & ~be_mask[CFG_W-1:0]) | wdat[CFG_W-1:0];
      end
      if (hit_ien) begin
        irq_en_q <= (irq_en_q & ~be_mask[IRQ_N-1:0]) | wdat[IRQ_N-1:0];
      end
    end
  end

  // Timer mode registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_timer_mode_reg_q <= '0;
      watch_timer_mode_reg_q <= '0;
    end else if (ce_i && wr_tm) begin
      interval_timer_mode_reg_q <=
        (interval_timer_mode_reg_q & ~be_mask[TM_IVL +: IVL_MODE_W])
        | wdat[TM_IVL +: IVL_MODE_W];
      watch_timer_mode_reg_q <=
        (watch_timer_mode_reg_q & ~be_mask[TM_WATCH +: WATCH_MODE_W])
        | wdat[TM_WATCH +: WATCH_MODE_W];
    end
  end

  // Interval counter; the flag set wins over a clear
  wire ivl_step = interval_run_o & interval_tick_i;
  wire ivl_wrap = ivl_step & (&interval_count_value_q);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_count_value_q <= '0;
      interval_timer_request_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (ivl_step) begin
        interval_count_value_q <= interval_count_value_q + 1'b1;
      end
      if (ivl_wrap) begin
        interval_timer_request_flag_q <= 1'b1;
      end else if (clr_ivl) begin
        interval_timer_request_flag_q <= 1'b0;
      end
    end
  end

  // Event counter source: external pin rising edge or internal tick
  wire pin_rise = counter_external_input_pin_i & !pin_q;
  wire cnt_src = cfg_q[CFG_CNT_PIN] ? pin_rise : counter_tick_i;
  wire cnt_step = counter_run_o & cnt_src;
  wire cnt_match = event_count_value_q == counter_modulo_reg_q;

  // Event counter with modulo match and square wave output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_count_value_q <= '0;
      counter_out_o <= 1'b0;
      pin_q <= 1'b0;
    end else if (ce_i) begin
      pin_q <= counter_external_input_pin_i;
      if (cnt_step && cnt_match) begin
        event_count_value_q <= '0;
        counter_out_o <= counter_out_o ^ counter_output_enable_q;
      end else if (cnt_step) begin
        event_count_value_q <= event_count_value_q + 1'b1;
      end
    end
  end

  // Counter control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_modulo_reg_q <= MODULO_RST;
      counter_mode_reg_q <= '0;
      counter_output_enable_q <= 1'b0;
    end else if (ce_i && wr_cn) begin
      counter_modulo_reg_q <= (counter_modulo_reg_q
        & ~be_mask[CN_MOD +: CNT_W]) | wdat[CN_MOD +: CNT_W];
      counter_mode_reg_q <= (counter_mode_reg_q
        & ~be_mask[CN_MODE +: CNT_W]) | wdat[CN_MODE +: CNT_W];
      counter_output_enable_q <= be_mask[CN_OE] ? wdat[CN_OE]
                                 : counter_output_enable_q;
    end
  end

  // Read words
  wire [DAT_W-1:0] rd_cmd = {29'h0, state_q};
  wire [DAT_W-1:0] rd_cfg = {27'h0, cfg_q};
  wire [DAT_W-1:0] rd_ien = {24'h0, irq_en_q};
  wire [DAT_W-1:0] rd_sts = {16'h0, live_src, ram_retain_o, main_osc_stop_o,
    cpu_clk_en_o, interval_run_o, serial_run_o, counter_run_o,
    watch_run_o, display_run_o};
  wire [DAT_W-1:0] rd_core = {8'h0, carry_flag_o, bank_select_reg_o,
    interrupt_status_flag_o, skip_flags_o, bank_enable_flag_o, pc_o};
  wire [DAT_W-1:0] rd_tm = {16'h0, watch_timer_mode_reg_q, 4'h0,
    interval_timer_mode_reg_q};
  wire [DAT_W-1:0] rd_cn = {event_count_value_q, 6'h0, counter_out_o,
    counter_output_enable_q, counter_mode_reg_q, counter_modulo_reg_q};
  wire [DAT_W-1:0] rd_iv = {23'h0, interval_timer_request_flag_q,
    interval_count_value_q};

  // Read select; unmapped addresses read zero
  assign rd_mux = hit_cmd ? rd_cmd : hit_cfg ? rd_cfg : hit_ien ? rd_ien
    : hit_sts ? rd_sts : hit_core ? rd_core : hit_tm ? rd_tm
    : hit_cn ? rd_cn : hit_iv ? rd_iv : '0;

  // Bus slave: ack one cycle after the request, for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req & !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_stop_refused_sub: assert property (
    ce_i && state_q == ST_RUN && cmd_stop && cfg_q[CFG_CPU_SUB]
    |=> state_q != ST_STOP)
    else $error("deep standby entered on subsystem clock");

  chk_halt_entry: assert property (
    ce_i && state_q == ST_RUN && cmd_halt && !cmd_stop |=> state_q == ST_HALT)
    else $error("light standby command not taken");

  chk_stop_osc_only: assert property (
    ce_i && state_q == ST_STOP |=> main_osc_stop_o && !cpu_clk_en_o)
    else $error("deep standby clock outputs wrong");

  chk_halt_cpu_gate: assert property (
    ce_i && state_q == ST_HALT |=> !cpu_clk_en_o && !main_osc_stop_o)
    else $error("light standby clock outputs wrong");

  chk_interval_stop: assert property (
    ce_i && state_q == ST_STOP |=> !interval_run_o ##1 !ivl_step)
    else $error("interval timer ran in deep standby");

  chk_halt_main_gone: assert property (
    ce_i && state_q == ST_HALT && !main_osc_ok_i
    |=> !interval_run_o && !serial_run_o && !counter_run_o)
    else $error("peripheral ran without main clock");

  chk_stop_serial_ext: assert property (
    ce_i && state_q == ST_STOP |=> serial_run_o == $past(cfg_q[CFG_SER_EXT]))
    else $error("serial enable wrong in deep standby");

  chk_stop_counter_pin: assert property (
    ce_i && state_q == ST_STOP |=> counter_run_o == $past(cfg_q[CFG_CNT_PIN]))
    else $error("counter enable wrong in deep standby");

  chk_stop_watch_disp: assert property (
    ce_i && state_q == ST_STOP |=> watch_run_o == $past(cfg_q[CFG_WATCH_SUB])
    && display_run_o == $past(cfg_q[CFG_DISP_SUB]))
    else $error("watch or display enable wrong in deep standby");

  chk_line_zero_dead: assert property (
    ce_i && standby && ((irq_req_i | ivl_vec) & irq_en_q & sb_mask) == '0
    |=> state_q == $past(state_q))
    else $error("standby left without enabled source");

  chk_wake_exit: assert property (
    ce_i && standby && (|(irq_req_i & irq_en_q & sb_mask))
    |=> state_q == ST_RUN ##1 !wake_o[*2])
    else $error("enabled request did not end standby");

  chk_reset_vector: assert property (
    $fell(rst_i) |-> pc_o == {$past(prog_word0_i[PC_HI_W-1:0]),
    $past(prog_word1_i)} && bank_enable_flag_o == $past(prog_word0_i[MBE_BIT]))
    else $error("reset vector not loaded");

  chk_reset_flags: assert property (
    $fell(rst_i) |-> skip_flags_o == '0 && !interrupt_status_flag_o
    && bank_select_reg_o == '0 && state_q == ST_RUN)
    else $error("core flags not cleared by reset");

  chk_carry_lost: assert property (
    $fell(rst_i) && !ram_retain_o |-> !carry_flag_o)
    else $error("carry kept on reset during operation");

  chk_timer_init: assert property (
    $fell(rst_i) |-> counter_modulo_reg_q == MODULO_RST
    && event_count_value_q == '0 && !counter_out_o
    && interval_timer_mode_reg_q == '0 && watch_timer_mode_reg_q == '0)
    else $error("timer registers not initialised");

  cov_stop_wake: cover property (state_q == ST_STOP ##1 state_q == ST_RUN);
  cov_halt_wake: cover property (state_q == ST_HALT ##1 state_q == ST_RUN);
  cov_halt_flag: cover property (state_q == ST_HALT && ivl_wrap);
  cov_retain: cover property ($fell(rst_i) && ram_retain_o);
endmodule

`default_nettype wire

// ---- sarc_far_model.sv ----
// Far-side model: main oscillator, timer ticks and count pin
`timescale 1ns/1ps
`default_nettype none

module sarc_far_model (
  input wire logic clk_i,
  input wire logic main_osc_stop_i,
  input wire logic osc_off_i,
  output logic main_osc_ok_o,
  output logic interval_tick_o,
  output logic counter_tick_o,
  output logic pin_o
);
  logic [1:0] div_q = 2'h0;
  // Oscillator halts while told to stop or failed by the bench
  always_ff @(posedge clk_i) begin
    main_osc_ok_o <= !main_osc_stop_i && !osc_off_i;
    div_q <= div_q + 2'h1;
  end
  // Ticks need a running main oscillator; the pin toggles freely
  assign interval_tick_o = main_osc_ok_o;
  assign counter_tick_o = main_osc_ok_o & div_q[0];
  assign pin_o = div_q[1];
endmodule

`default_nettype wire

// ---- standby_and_reset_control_bench.sv ----
// Bench for the standby and reset control block
`timescale 1ns/1ps
`default_nettype none

module standby_and_reset_control_bench;
  import sarc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, irq = 8'h00, w0 = 8'hab, w1 = 8'h5c;
  logic [31:0] wdat = 32'h0, rdat, dat_o, tmp;
  logic ack, osc_ok, itick, ctick, pin, stop, cpu, ivl, ser, cnt, wat, dis;
  logic wake, bef, ist, cy, ret, hole, tout;
  logic osc_off = 1'b0;
  logic [13:0] pc;
  logic [2:0] sk;
  logic [3:0] bank_select_reg;
  int err_total = 0, samples_checked = 0;
  wire [6:0] runs = {stop, cpu, ivl, ser, cnt, wat, dis};

  initial forever #10 clk = ~clk;

  sarc_top i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dat_o), .irq_req_i(irq),
    .main_osc_ok_i(osc_ok), .prog_word0_i(w0), .prog_word1_i(w1),
    .interval_tick_i(itick), .counter_tick_i(ctick),
    .counter_external_input_pin_i(pin), .main_osc_stop_o(stop),
    .cpu_clk_en_o(cpu), .interval_run_o(ivl), .serial_run_o(ser),
    .counter_run_o(cnt), .watch_run_o(wat), .display_run_o(dis),
    .wake_o(wake), .pc_o(pc), .bank_enable_flag_o(bef), .skip_flags_o(sk),
    .interrupt_status_flag_o(ist), .bank_select_reg_o(bank_select_reg),
    .carry_flag_o(cy), .ram_retain_o(ret), .ram_hole_clear_o(hole),
    .counter_out_o(tout));

  sarc_far_model i_far (.clk_i(clk), .main_osc_stop_i(stop),
    .osc_off_i(osc_off),
    .main_osc_ok_o(osc_ok), .interval_tick_o(itick),
    .counter_tick_o(ctick), .pin_o(pin));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Waits a bounded span for the wake pulse, reports whether it came
  task automatic wait_wake(input int n, input logic e);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake", {31'h0, e}, {31'h0, seen});
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    cyc_n(2);
    #1 chk("hole", 32'h1, {31'h0, hole});
    @(posedge clk);
    rst <= 1'b0;
    cyc_n(2);
  endtask

  initial begin
    #(20 * 20000);
    chk("watchdog", 32'h0, 32'h1);
    print_verdict();
  end

  initial begin
    cyc_n(2);
    rst <= 1'b0;
    cyc_n(2);
    chk("pc", 32'h2b5c, {18'h0, pc});
    chk("mbe", 32'h1, {31'h0, bef});
    chk("flags", 32'h0, {24'h0, sk, ist, bank_select_reg});
    // Count field moves on internal ticks, so it is masked off
    wb(1'b0, OFS_COUNTER, 32'h0);
    chk("counter", 32'h000000ff, rdat & 32'h00ffffff);
    rd("unmapped", 8'h20, 32'h0);
    rd("state", OFS_CMD, 32'h1);
    chk("runs", 32'h3f, {25'h0, runs});
    // Light standby on main clock, line zero must not wake
    wb(1'b1, OFS_IRQ_EN, 32'h03);
    wb(1'b1, OFS_CMD, 32'h2);
    cyc_n(1);
    chk("light", 32'h1f, {25'h0, runs});
    // Main oscillator fails while in light standby
    osc_off <= 1'b1;
    cyc_n(3);
    chk("light no main", 32'h03, {25'h0, runs});
    osc_off <= 1'b0;
    rd("state", OFS_CMD, 32'h4);
    irq <= 8'h01;
    wait_wake(20, 1'b0);
    irq <= 8'h03;
    wait_wake(5, 1'b1);
    irq <= 8'h00;
    rd("state", OFS_CMD, 32'h1);
    // Processor on subsystem clock: deep refused, light taken
    wb(1'b1, OFS_CFG, 32'h01);
    wb(1'b1, OFS_CMD, 32'h1);
    rd("state", OFS_CMD, 32'h1);
    wb(1'b1, OFS_CMD, 32'h3);
    rd("state", OFS_CMD, 32'h4);
    irq <= 8'h02;
    wait_wake(5, 1'b1);
    irq <= 8'h00;
    // Deep standby with two peripheral source patterns
    wb(1'b1, OFS_IRQ_EN, 32'h0d);
    wb(1'b1, OFS_CFG, 32'h0a);
    wb(1'b1, OFS_CMD, 32'h1);
    cyc_n(1);
    chk("deep a", 32'h4a, {25'h0, runs});
    wb(1'b0, OFS_INTERVAL, 32'h0);
    tmp = rdat;
    cyc_n(40);
    rd("ivl hold", OFS_INTERVAL, tmp);
    irq <= 8'h08;
    wait_wake(5, 1'b1);
    irq <= 8'h00;
    wb(1'b1, OFS_CFG, 32'h14);
    wb(1'b1, OFS_CMD, 32'h1);
    cyc_n(1);
    chk("deep b", 32'h45, {25'h0, runs});
    irq <= 8'h04;
    wait_wake(5, 1'b1);
    irq <= 8'h00;
    // Interval request raised in light standby ends it
    wb(1'b1, OFS_CFG, 32'h00);
    wb(1'b1, OFS_IRQ_EN, 32'h10);
    wb(1'b1, OFS_INTERVAL, 32'h100);
    wb(1'b1, OFS_CMD, 32'h2);
    wait_wake(300, 1'b1);
    // Flag stays set, so its enable goes before deep standby
    wb(1'b1, OFS_IRQ_EN, 32'h00);
    // Reset in deep standby keeps carry and retention, loads the new vector, initialises the rest
    wb(1'b1, OFS_CORE, 32'h00ff8000);
    wb(1'b1, OFS_COUNTER, 32'h00015a10);
    wb(1'b1, OFS_TMODE, 32'h0000ab0c);
    wb(1'b1, OFS_CMD, 32'h1);
    w0 <= 8'h3f;
    w1 <= 8'h01;
    do_reset();
    chk("retain", 32'h3, {30'h0, cy, ret});
    chk("pc mbe", 32'h3f01, {17'h0, bef, pc});
    chk("flags", 32'h0, {24'h0, sk, ist, bank_select_reg});
    chk("tout", 32'h0, {31'h0, tout});
    rd("tmode", OFS_TMODE, 32'h0);
    wb(1'b0, OFS_COUNTER, 32'h0);
    chk("counter", 32'h000000ff, rdat & 32'h00ffffff);
    rd("state", OFS_CMD, 32'h1);
    // Reset during operation loses carry and retention
    wb(1'b1, OFS_CORE, 32'h00800000);
    do_reset();
    chk("no retain", 32'h0, {30'h0, cy, ret});
    print_verdict();
  end
endmodule

`default_nettype wire
